// ---- logic/fdc_cmd_pkg.sv ----
// constants and types shared by the command and seek control block
package fdc_cmd_pkg;
  localparam int unsigned CLK_HZ      = 8000000;  // core clock rate
  localparam int unsigned CLK_NS      = 125;      // core clock period
  localparam int unsigned STEP6_MS    = 6;        // step rate codes
  localparam int unsigned STEP12_MS   = 12;
  localparam int unsigned STEP2_MS    = 2;
  localparam int unsigned STEP3_MS    = 3;
  localparam int unsigned PULSE_DD_US = 4;        // step pulse widths
  localparam int unsigned PULSE_SD_US = 8;
  localparam int unsigned DIR_US      = 24;       // direction setup
  localparam int unsigned VSETTLE_MS  = 30;       // verify head settle
  localparam int unsigned ESETTLE_MS  = 15;       // e-flag settle default
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1000000;
  localparam int unsigned STEP6_CYC   = STEP6_MS * CYC_PER_MS;
  localparam int unsigned STEP12_CYC  = STEP12_MS * CYC_PER_MS;
  localparam int unsigned STEP2_CYC   = STEP2_MS * CYC_PER_MS;
  localparam int unsigned STEP3_CYC   = STEP3_MS * CYC_PER_MS;
  localparam int unsigned PULSE_DD_CYC = PULSE_DD_US * CYC_PER_US;
  localparam int unsigned PULSE_SD_CYC = PULSE_SD_US * CYC_PER_US;
  localparam int unsigned DIR_CYC     = DIR_US * CYC_PER_US;
  localparam int unsigned VSETTLE_CYC = VSETTLE_MS * CYC_PER_MS;
  localparam int unsigned ESETTLE_CYC = ESETTLE_MS * CYC_PER_MS;
  localparam int unsigned SPINUP_REVS = 6;        // index pulses at spin-up
  localparam int unsigned IDLE_REVS   = 10;       // idle pulses before motor off
  localparam int unsigned VERIFY_REVS = 5;        // verify search window
  localparam int unsigned RESTORE_MAX = 255;      // restore step limit
  // command word fields
  localparam int unsigned B_RATE_LO   = 0;
  localparam int unsigned B_RATE_HI   = 1;
  localparam int unsigned B_MARK      = 0;
  localparam int unsigned B_PRECOMP   = 1;
  localparam int unsigned B_VERIFY    = 2;
  localparam int unsigned B_SPINOFF   = 3;
  localparam int unsigned B_UPDATE    = 4;
  localparam int unsigned B_FI_INDEX  = 2;
  localparam int unsigned B_FI_NOW    = 3;
  localparam logic [3:0]  OP_RESTORE  = 4'h0;
  localparam logic [3:0]  OP_SEEK     = 4'h1;
  localparam logic [3:0]  OP_RDADDR   = 4'hC;
  localparam logic [3:0]  OP_FORCE    = 4'hD;
  localparam logic [3:0]  OP_RDTRK    = 4'hE;
  localparam logic [3:0]  OP_WRTRK    = 4'hF;
  localparam logic [2:0]  OP_STEP     = 3'h1;
  localparam logic [2:0]  OP_STEPIN   = 3'h2;
  localparam logic [2:0]  OP_STEPOUT  = 3'h3;
  localparam logic [2:0]  OP_RDSEC    = 3'h4;
  localparam logic [2:0]  OP_WRSEC    = 3'h5;
  localparam logic [7:0]  TRACK_ZERO  = 8'h00;
  localparam logic [7:0]  ONE_TRACK   = 8'h01;
  typedef enum logic [3:0] {
    C_RESTORE = 4'h0, C_SEEK = 4'h1, C_STEP = 4'h2, C_STEPIN = 4'h3,
    C_STEPOUT = 4'h4, C_RDSEC = 4'h5, C_WRSEC = 4'h6, C_RDADDR = 4'h7,
    C_RDTRK = 4'h8, C_WRTRK = 4'h9, C_FORCE = 4'hA
  } cmd_e;
endpackage

// ---- logic/fdc_cmd_seek_ctrl.sv ----
// command decode, busy/interrupt, spindle motor and head positioning control
// Functional notes
// - busy during command; done clears busy, interrupts
// - rate field selects 6/12/2/3 ms steps
// - step pulse 4 us double, 8 us single
// - direction high inward, set 24 us early
// - verify waits 30 ms settle after stepping
// - verify compares id track with track register
// - matching track with bad crc sets crc error
// - no good id in five revs: seek error
// - motor off and spin-up enabled: six revs wait
// - ten idle revolutions turn motor off
// - motor already on: execute at once
// - bit 3 set disables spin-up sequence
// - upper nibble decodes the eleven commands
// - step commands bit 4 updates track register
// - sector commands bit 4 selects multiple sectors
// - write sector bit 0 selects deleted mark
// - write commands bit 1 disables precompensation
// - sector/address/track bit 2 adds settle delay
// - force interrupt: index, immediate, or silent terminate
// - restore steps out until track zero seen
// - restore gives up after 255 steps
// - interrupt cleared by status read or command write
// - density select low double, high single
`timescale 1ns/100ps
module fdc_cmd_seek_ctrl
  import fdc_cmd_pkg::*;
#(
  parameter int unsigned TW          = 20,           // timer width
  parameter int unsigned E_SETTLE_CYC = ESETTLE_CYC, // e-flag settle cycles
  parameter int unsigned V_SETTLE_CYC = VSETTLE_CYC  // verify settle cycles
) (
  input  wire logic       i_core_clk,            // core clock, 8 MHz
  input  wire logic       i_rstn,                // sync reset, active low
  input  wire logic       i_cmd_wr,              // command word write strobe
  input  wire logic [7:0] i_cmd,                 // command word
  input  wire logic       i_status_rd,           // status register read strobe
  input  wire logic [7:0] i_data_reg,            // desired track for seek
  input  wire logic       i_track_wr,            // track register write
  input  wire logic [7:0] i_track_wdata,         // track register write data
  input  wire logic       i_id_valid,            // id field found, one pulse
  input  wire logic [7:0] i_id_track,            // id field track number
  input  wire logic       i_id_crc_ok,           // id field crc good
  input  wire logic       i_xfer_done,           // type ii/iii body finished
  input  wire logic       i_xfer_error,          // type ii/iii body error
  input  wire logic       i_index_pin,           // index pulse pin
  input  wire logic       i_track_zero_sense_n,  // track zero pin, low at 0
  input  wire logic       i_density_select_n,    // low double, high single
  output logic            o_busy,                // status bit 0
  output logic            o_crc_error,           // status bit 3
  output logic            o_seek_error,          // seek error status
  output logic            o_interrupt_request_out, // interrupt to host
  output logic [7:0]      o_track,               // track register
  output logic            o_step,                // step pulse to drive
  output logic            o_direction,           // high = stepping in
  output logic            o_motor_on,            // spindle motor on
  output logic            o_xfer_start,          // start type ii/iii body
  output logic            o_multi_sector,        // multiple sector mode
  output logic            o_deleted_mark_select, // write deleted mark
  output logic            o_precomp_en,          // write precompensation on
  output logic [3:0]      o_cmd_kind             // decoded command
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SPIN = 4'h1, S_PLAN = 4'h2, S_DIRSET = 4'h3,
    S_PULSE = 4'h4, S_GAP = 4'h5, S_SETTLE = 4'h6, S_VERIFY = 4'h7,
    S_ESET = 4'h8, S_XFER = 4'h9, S_DONE = 4'hA
  } st_e;

  // pin synchronisers: first stage only feeds second stage
  logic [1:0] idx_s_q, tz_s_q, den_s_q;          // 2-flop chains
  logic       idx_old_q;                         // index edge history
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      idx_s_q   <= 2'h0;
      tz_s_q    <= 2'h3;
      den_s_q   <= 2'h0;
      idx_old_q <= 1'b0;
    end else begin
      idx_s_q   <= {idx_s_q[0], i_index_pin};
      tz_s_q    <= {tz_s_q[0], i_track_zero_sense_n};
      den_s_q   <= {den_s_q[0], i_density_select_n};
      idx_old_q <= idx_s_q[1];
    end
  end
  wire index_rise = idx_s_q[1] & ~idx_old_q;     // one pulse per revolution
  wire at_zero    = ~tz_s_q[1];                  // track zero reached
  wire single_den = den_s_q[1];

  // command decode
  function automatic cmd_e decode(input logic [7:0] c);
    unique case (c[7:4])
      OP_RESTORE: decode = C_RESTORE;
      OP_SEEK:    decode = C_SEEK;
      OP_RDADDR:  decode = C_RDADDR;
      OP_FORCE:   decode = C_FORCE;
      OP_RDTRK:   decode = C_RDTRK;
      OP_WRTRK:   decode = C_WRTRK;
      default: begin
        unique case (c[7:5])
          OP_STEP:    decode = C_STEP;
          OP_STEPIN:  decode = C_STEPIN;
          OP_STEPOUT: decode = C_STEPOUT;
          OP_RDSEC:   decode = C_RDSEC;
          default:    decode = C_WRSEC;
        endcase
      end
    endcase
  endfunction

  // step interval from the rate field
  function automatic logic [TW-1:0] rate_cyc(input logic [1:0] r);
    unique case (r)
      2'h0: rate_cyc = TW'(STEP6_CYC);
      2'h1: rate_cyc = TW'(STEP12_CYC);
      2'h2: rate_cyc = TW'(STEP2_CYC);
      default: rate_cyc = TW'(STEP3_CYC);
    endcase
  endfunction

  st_e        st_q, st_d;                        // sequencer state
  cmd_e       kind_q, kind_d;                    // current command
  logic [7:0] cw_q, cw_d;                        // latched command word
  logic [7:0] trk_q, trk_d;                      // track register
  logic       dir_q, dir_d;                      // direction, kept across commands
  logic       busy_q, busy_d;
  logic       irq_q, irq_d;
  logic       crc_q, crc_d, seek_q, seek_d;      // error status
  logic       mot_q, mot_d;
  logic [3:0] revs_q, revs_d;                    // revolution counter
  logic [7:0] nsteps_q, nsteps_d;                // restore step count
  logic       fi_idx_q, fi_idx_d;                // armed index interrupt
  logic       xs_q, xs_d;                        // transfer start pulse
  logic       tload;                             // timer start
  logic [TW-1:0] tcyc;                           // timer length
  logic       tdone;                             // timer expiry

  fdc_interval_timer #(.W(TW)) u_timer (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_load     (tload),
    .i_cycles   (tcyc),
    .o_done     (tdone)
  );

  wire is_type1 = (kind_q == C_RESTORE) || (kind_q == C_SEEK) || (kind_q == C_STEP)
               || (kind_q == C_STEPIN) || (kind_q == C_STEPOUT);
  wire verify   = cw_q[B_VERIFY];
  wire [TW-1:0] pulse_cyc = single_den ? TW'(PULSE_SD_CYC) : TW'(PULSE_DD_CYC);

  // command sequencer next state
  always_comb begin
    cmd_e k;
    k        = decode(i_cmd);
    st_d     = st_q;
    kind_d   = kind_q;
    cw_d     = cw_q;
    trk_d    = i_track_wr ? i_track_wdata : trk_q;
    dir_d    = dir_q;
    busy_d   = busy_q;
    irq_d    = irq_q;
    crc_d    = crc_q;
    seek_d   = seek_q;
    mot_d    = mot_q;
    revs_d   = revs_q;
    nsteps_d = nsteps_q;
    fi_idx_d = fi_idx_q;
    xs_d     = 1'b0;
    tload    = 1'b0;
    tcyc     = '0;
    if (i_status_rd) irq_d = 1'b0;
    // idle spindle timeout counts index pulses while nothing runs
    if (st_q == S_IDLE && mot_q && index_rise) begin
      revs_d = revs_q + 4'h1;
      if (revs_q == 4'(IDLE_REVS - 1)) begin
        mot_d  = 1'b0;
        revs_d = 4'h0;
      end
    end
    // armed index interrupt fires on the next index pulse
    if (fi_idx_q && index_rise) begin
      irq_d    = 1'b1;
      fi_idx_d = 1'b0;
    end
    unique case (st_q)
      S_IDLE: ;
      S_SPIN: if (index_rise) begin
        revs_d = revs_q + 4'h1;
        if (revs_q == 4'(SPINUP_REVS - 1)) begin
          revs_d = 4'h0;
          st_d   = S_PLAN;
        end
      end
      S_PLAN: begin
        if (!is_type1) begin
          if (cw_q[B_VERIFY]) begin
            tload = 1'b1;
            tcyc  = TW'(E_SETTLE_CYC);
            st_d  = S_ESET;
          end else begin
            xs_d = 1'b1;
            st_d = S_XFER;
          end
        end else if (kind_q == C_RESTORE) begin
          if (at_zero) begin
            trk_d = TRACK_ZERO;
            st_d  = verify ? S_SETTLE : S_DONE;
            tload = verify;
            tcyc  = TW'(V_SETTLE_CYC);
          end else if (nsteps_q == 8'(RESTORE_MAX)) begin
            seek_d = verify;
            st_d   = S_DONE;
          end else begin
            dir_d = 1'b0;
            tload = 1'b1;
            tcyc  = TW'(DIR_CYC);
            st_d  = S_DIRSET;
          end
        end else if (kind_q == C_SEEK && trk_q == i_data_reg) begin
          st_d  = verify ? S_SETTLE : S_DONE;
          tload = verify;
          tcyc  = TW'(V_SETTLE_CYC);
        end else begin
          if (kind_q == C_SEEK) dir_d = (i_data_reg > trk_q);
          if (kind_q == C_STEPIN) dir_d = 1'b1;
          if (kind_q == C_STEPOUT) dir_d = 1'b0;
          tload = 1'b1;
          tcyc  = TW'(DIR_CYC);
          st_d  = S_DIRSET;
        end
      end
      S_DIRSET: if (tdone) begin
        tload = 1'b1;
        tcyc  = pulse_cyc;
        st_d  = S_PULSE;
      end
      S_PULSE: if (tdone) begin
        if (kind_q == C_RESTORE) nsteps_d = nsteps_q + 8'h01;
        if (kind_q == C_SEEK || cw_q[B_UPDATE])
          trk_d = dir_q ? trk_q + ONE_TRACK : trk_q - ONE_TRACK;
        tload = 1'b1;
        tcyc  = rate_cyc(cw_q[B_RATE_HI:B_RATE_LO]);
        st_d  = S_GAP;
      end
      S_GAP: if (tdone) begin
        if (kind_q == C_RESTORE || kind_q == C_SEEK) begin
          st_d = S_PLAN;
        end else begin
          st_d  = verify ? S_SETTLE : S_DONE;
          tload = verify;
          tcyc  = TW'(V_SETTLE_CYC);
        end
      end
      S_SETTLE: if (tdone) begin
        revs_d = 4'h0;
        st_d   = S_VERIFY;
      end
      S_VERIFY: begin
        if (i_id_valid && i_id_track == trk_q) begin
          if (i_id_crc_ok) st_d = S_DONE;
          else crc_d = 1'b1;
        end else if (index_rise) begin
          revs_d = revs_q + 4'h1;
          if (revs_q == 4'(VERIFY_REVS - 1)) begin
            seek_d = 1'b1;
            st_d   = S_DONE;
          end
        end
      end
      S_ESET: if (tdone) begin
        xs_d = 1'b1;
        st_d = S_XFER;
      end
      S_XFER: if (i_xfer_done) begin
        crc_d = i_xfer_error;
        st_d  = S_DONE;
      end
      S_DONE: begin
        busy_d = 1'b0;
        irq_d  = 1'b1;
        revs_d = 4'h0;
        st_d   = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    // command write: only force interrupt is accepted while busy
    if (i_cmd_wr) begin
      irq_d = 1'b0;
      if (k == C_FORCE) begin
        fi_idx_d = i_cmd[B_FI_INDEX];
        if (i_cmd[B_FI_NOW]) irq_d = 1'b1;
        busy_d = 1'b0;
        revs_d = 4'h0;
        st_d   = S_IDLE;
        kind_d = C_FORCE;
      end else if (!busy_q) begin
        kind_d   = k;
        cw_d     = i_cmd;
        busy_d   = 1'b1;
        crc_d    = 1'b0;
        seek_d   = 1'b0;
        nsteps_d = 8'h00;
        revs_d   = 4'h0;
        if (!i_cmd[B_SPINOFF] && !mot_q) begin
          mot_d = 1'b1;
          st_d  = S_SPIN;
        end else begin
          st_d = S_PLAN;
        end
      end
    end
    // a completion or an armed index event beats a clear in the same cycle
    if (st_q == S_DONE || (fi_idx_q && index_rise)) irq_d = 1'b1;
  end

  // sequencer registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st_q <= S_IDLE;  kind_q <= C_RESTORE; cw_q <= 8'h00; trk_q <= 8'h00;
      dir_q <= 1'b0;   busy_q <= 1'b0;      irq_q <= 1'b0; crc_q <= 1'b0;
      seek_q <= 1'b0;  mot_q <= 1'b0;       revs_q <= 4'h0; nsteps_q <= 8'h00;
      fi_idx_q <= 1'b0; xs_q <= 1'b0;
    end else begin
      st_q <= st_d;    kind_q <= kind_d;    cw_q <= cw_d;  trk_q <= trk_d;
      dir_q <= dir_d;  busy_q <= busy_d;    irq_q <= irq_d; crc_q <= crc_d;
      seek_q <= seek_d; mot_q <= mot_d;     revs_q <= revs_d; nsteps_q <= nsteps_d;
      fi_idx_q <= fi_idx_d; xs_q <= xs_d;
    end
  end

  assign o_busy                  = busy_q;
  assign o_crc_error             = crc_q;
  assign o_seek_error            = seek_q;
  assign o_interrupt_request_out = irq_q;
  assign o_track                 = trk_q;
  assign o_step                  = (st_q == S_PULSE);
  assign o_direction             = dir_q;
  assign o_motor_on              = mot_q;
  assign o_xfer_start            = xs_q;
  assign o_multi_sector          = cw_q[B_UPDATE];
  assign o_deleted_mark_select   = cw_q[B_MARK];
  assign o_precomp_en            = ~cw_q[B_PRECOMP];
  assign o_cmd_kind              = kind_q;

  // assertions
  a_busy_ends_irq: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (st_q == S_DONE) |=> (!busy_q && irq_q))
    else $error("completion did not clear busy and raise interrupt");
  a_step_width: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    $rose(o_step) && !single_den |-> o_step[*4] ##1 o_step[*8])
    else $error("step pulse shorter than minimum");
  a_dir_stable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_step |-> $stable(o_direction))
    else $error("direction changed during step");
  a_spin_motor: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (st_q == S_SPIN) |-> o_motor_on)
    else $error("spin-up without motor on");
  a_restore_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (st_q == S_PLAN && kind_q == C_RESTORE && at_zero && !i_cmd_wr) |=> (trk_q == TRACK_ZERO))
    else $error("restore did not clear track");
  a_irq_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_status_rd && st_q != S_DONE && !fi_idx_q && !i_cmd_wr) |=> !irq_q)
    else $error("status read did not clear interrupt");
  a_force_now: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_cmd_wr && i_cmd[7:4] == OP_FORCE && st_q != S_DONE && !(fi_idx_q && index_rise))
    |=> (!busy_q && (irq_q == $past(i_cmd[B_FI_NOW]))))
    else $error("force interrupt mishandled");
  a_restore_limit: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (st_q == S_PULSE && kind_q == C_RESTORE) |-> (nsteps_q < 8'(RESTORE_MAX)))
    else $error("restore stepped beyond the step limit");
endmodule

// ---- logic/fdc_interval_timer.sv ----
// loadable down-counter that flags the end of a timed interval
`timescale 1ns/100ps
module fdc_interval_timer #(
  parameter int unsigned W = 20                  // counter width
) (
  input  wire logic         i_core_clk,          // core clock
  input  wire logic         i_rstn,              // sync reset, active low
  input  wire logic         i_load,              // start a new interval
  input  wire logic [W-1:0] i_cycles,            // interval length in cycles
  output logic              o_done               // one-cycle pulse at expiry
);
  logic [W-1:0] cnt_q, cnt_d;                    // remaining cycles
  logic         run_q, run_d;                    // interval in progress
  logic         done_q, done_d;                  // expiry pulse

  // next state: load wins over counting so a restart is never lost
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (i_load) begin
      cnt_d = i_cycles - W'(1);                  // the registered expiry supplies the last cycle
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= W'(1)) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
endmodule

// ---- tb/fdc_cmd_seek_ctrl_tb.sv ----
// self-checking bench for the command and seek control block
`timescale 1ns/100ps
module fdc_cmd_seek_ctrl_tb;
  import fdc_cmd_pkg::*;
  localparam int unsigned REV = 200;  // short revolution keeps the run brief
  localparam int unsigned VSET = 100; // shortened verify settle
  localparam int unsigned ESET = 300; // shortened e-flag settle
  logic i_core_clk = 0, i_rstn = 0, i_cmd_wr = 0, i_status_rd = 0, i_track_wr = 0;
  logic i_id_valid = 0, i_id_crc_ok = 0, i_xfer_done = 0, i_xfer_error = 0;
  logic i_index_pin, i_track_zero_sense_n, i_density_select_n = 0;
  logic [7:0] i_cmd = 8'h00, i_data_reg = 8'h00, i_track_wdata = 8'h00, i_id_track = 8'h00;
  logic o_busy, o_crc_error, o_seek_error, o_interrupt_request_out, o_step, o_direction;
  logic o_motor_on, o_xfer_start, o_multi_sector, o_deleted_mark_select, o_precomp_en;
  logic [7:0] o_track;
  logic [3:0] o_cmd_kind;
  int n_errors = 0, checks_done = 0, cyc = 0, pw = 0, width = 0, since = 0, lead = 0, n;
  logic st_q = 0, dir_q = 0;
  logic [7:0] ops[3] = '{8'h98, 8'hAB, 8'hF8};
  logic [3:0] kinds[3] = '{C_RDSEC, C_WRSEC, C_WRTRK};
  fdc_cmd_seek_ctrl #(.E_SETTLE_CYC(ESET), .V_SETTLE_CYC(VSET)) dut (.i_core_clk, .i_rstn,
    .i_cmd_wr, .i_cmd, .i_status_rd, .i_data_reg,
    .i_track_wr, .i_track_wdata, .i_id_valid, .i_id_track, .i_id_crc_ok, .i_xfer_done,
    .i_xfer_error, .i_index_pin, .i_track_zero_sense_n, .i_density_select_n, .o_busy,
    .o_crc_error, .o_seek_error, .o_interrupt_request_out, .o_track, .o_step, .o_direction,
    .o_motor_on, .o_xfer_start, .o_multi_sector, .o_deleted_mark_select, .o_precomp_en,
    .o_cmd_kind);
  fdc_drive_model #(.REV_CYC(REV)) drive (.i_core_clk, .i_step(o_step),
    .i_direction(o_direction), .o_index(i_index_pin), .o_tz_n(i_track_zero_sense_n));
  initial forever #10 i_core_clk = ~i_core_clk;
  // step width and direction lead are measured on the wire, not trusted from the design
  always @(posedge i_core_clk) begin
    cyc   <= cyc + 1;
    st_q  <= o_step;
    dir_q <= o_direction;
    pw    <= o_step ? pw + 1 : 0;
    since <= (o_direction != dir_q) ? 0 : since + 1;
    if (!o_step && st_q) width <= pw;
    if (o_step && !st_q) lead <= since;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // command write strobe, held for one sampling edge
  task automatic cmd(input logic [7:0] b);
    @(posedge i_core_clk);
    i_cmd_wr <= 1'b1;
    i_cmd    <= b;
    @(posedge i_core_clk);
    i_cmd_wr <= 1'b0;
    #1;
  endtask
  // one-cycle strobe: status read when rd, else body done
  task automatic strobe(input bit rd);
    @(posedge i_core_clk);
    if (rd) i_status_rd <= 1'b1;
    else i_xfer_done <= 1'b1;
    @(posedge i_core_clk);
    i_status_rd <= 1'b0;
    i_xfer_done <= 1'b0;
    #1;
  endtask
  // one id field from the read path, present for one sampling edge
  task automatic id_field(input logic [7:0] t, input bit ok);
    @(posedge i_core_clk);
    i_id_valid  <= 1'b1;
    i_id_track  <= t;
    i_id_crc_ok <= ok;
    @(posedge i_core_clk);
    i_id_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_idle(output int c);
    c = 0;
    while (o_busy === 1'b1 && c < 40000) begin
      @(posedge i_core_clk);
      #1;
      c++;
    end
    chk("busy", 0, o_busy);
  endtask
  task automatic wait_start(output int c);
    c = 0;
    while (o_xfer_start !== 1'b1 && c < 12 * REV) begin
      @(posedge i_core_clk);
      #1;
      c++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    #1;
    chk("busy", 0, o_busy);
    chk("precomp", 1, o_precomp_en);
    chk("motor", 0, o_motor_on);
    $display("test reset done");
    // motor off and spin-up enabled: six index revolutions first
    cmd(8'hC0);
    chk("busy", 1, o_busy);
    wait_start(n);
    chk("motor", 1, o_motor_on);
    chk("spinup", 1, n >= 5 * REV && n < 7 * REV);
    strobe(0);
    wait_idle(n);
    chk("irq", 1, o_interrupt_request_out);
    chk("kind", C_RDADDR, o_cmd_kind);
    $display("test spin-up done");
    // motor already on: the bodies start at once
    for (int k = 0; k < 3; k++) begin
      cmd(ops[k]);
      wait_start(n);
      chk("prompt", 1, n < 8);
      chk("kind", kinds[k], o_cmd_kind);
      chk("precomp", !ops[k][1], o_precomp_en);
      if (k < 2) begin
        chk("multi", ops[k][4], o_multi_sector);
        chk("deleted", ops[k][0], o_deleted_mark_select);
      end
      strobe(0);
      wait_idle(n);
    end
    // e flag: the body starts only after the settle delay
    cmd(8'hCC);
    wait_start(n);
    chk("settle", 1, n >= ESET && n < ESET + 8);
    strobe(0);
    wait_idle(n);
    strobe(1);
    chk("irq", 0, o_interrupt_request_out);
    $display("test decode done");
    // refused write while busy, then force conditions
    cmd(8'hE8);
    cmd(8'h5A);
    chk("kind", C_RDTRK, o_cmd_kind);
    cmd(8'hD0);
    wait_idle(n);
    chk("irq", 0, o_interrupt_request_out);
    cmd(8'hD8);
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("irq", 1, o_interrupt_request_out);
    strobe(1);
    cmd(8'hD4);
    repeat (REV + 10) @(posedge i_core_clk);
    #1;
    chk("irq", 1, o_interrupt_request_out);
    strobe(1);
    $display("test force done");
    // step in, track update, 2 ms rate, double density
    cmd(8'h5A);
    wait_idle(n);
    chk("dir", 1, o_direction);
    chk("lead", 1, lead >= DIR_CYC - 1);
    chk("width", PULSE_DD_CYC, width);
    chk("gap", 1, n >= STEP2_CYC && n < STEP2_CYC + 400);
    chk("track", 1, o_track);
    chk("irq", 1, o_interrupt_request_out);
    $display("test step-in done");
    // restore with verify in single density from track one: bad crc first, then a good id
    @(posedge i_core_clk);
    i_density_select_n <= 1'b1;
    cmd(8'h0E);
    chk("irq", 0, o_interrupt_request_out);
    repeat (16500) @(posedge i_core_clk);
    id_field(8'h00, 1'b0);
    chk("crc", 1, o_crc_error);
    chk("busy", 1, o_busy);
    id_field(8'h00, 1'b1);
    wait_idle(n);
    chk("seek", 0, o_seek_error);
    chk("track", 0, o_track);
    chk("dir", 0, o_direction);
    chk("width", PULSE_SD_CYC, width);
    chk("irq", 1, o_interrupt_request_out);
    $display("test restore done");
    // seek onto the current track with verify and no id fields: seek error after five revolutions
    cmd(8'h1C);
    chk("kind", C_SEEK, o_cmd_kind);
    wait_idle(n);
    chk("seek", 1, o_seek_error);
    chk("crc", 0, o_crc_error);
    chk("window", 1, n >= VSET + 4 * REV && n < VSET + 5 * REV + 8);
    chk("irq", 1, o_interrupt_request_out);
    $display("test verify done");
    // motor stays on for ten idle revolutions, then drops
    repeat (8 * REV) @(posedge i_core_clk);
    #1;
    chk("motor", 1, o_motor_on);
    repeat (4 * REV) @(posedge i_core_clk);
    #1;
    chk("motor", 0, o_motor_on);
    $display("test motor done");
    results();
  end
endmodule

// ---- tb/fdc_drive_model.sv ----
// behavioural floppy drive: index pulses, head position and track zero sensor
`timescale 1ns/100ps
module fdc_drive_model #(
  parameter int unsigned REV_CYC = 200  // cycles per revolution, shortened
) (
  input  wire logic i_core_clk,   // core clock
  input  wire logic i_step,       // step pulse from controller
  input  wire logic i_direction,  // high = inward
  output logic      o_index,      // index pulse, 4 cycles a revolution
  output logic      o_tz_n        // low while head sits on track zero
);
  int unsigned rev_q  = 0;     // position within a revolution
  int unsigned head_q = 0;     // head position in tracks
  logic        st_q   = 1'b0;  // last step level
  // one track per rising step edge; the end stop keeps the head at zero
  always @(posedge i_core_clk) begin
    rev_q <= (rev_q == REV_CYC - 1) ? 0 : rev_q + 1;
    st_q  <= i_step;
    if (i_step && !st_q) begin
      head_q <= i_direction ? head_q + 1 : (head_q == 0 ? 0 : head_q - 1);
    end
  end
  assign o_index = (rev_q < 4);
  assign o_tz_n  = (head_q != 0);
endmodule
